// ---- inc/aur_defines.svh ----
// Purpose: constants of the asynchronous receiver with address detection
// Assumes: registers are 8 bits wide on a plain strobe port
// Notes: offsets are word indices on the register port
//
// Notes on behaviour
// [RQ1] FIFO holds two characters; a third complete one sets overrun.
// [RQ2] During overrun held characters stay readable, no new ones enter.
// [RQ3] Software clears overrun by clearing continuous receive enable.
// [RQ4] Nine-bit enable makes each character nine data bits long.
// [RQ5] Ninth-bit status always shows bit nine of the head character.
// [RQ6] Software reads ninth-bit status before data; data read pops.
// [RQ7] Address detect stores only characters with ninth bit one.
// [RQ8] Software enables nine-bit mode whenever address detect is on.
// [RQ9] After own address matches, software clears address detect quickly.
// [RQ10] At message end software sets address detect again.
// [RQ11] Without address detect every character is stored and pending.
// [RQ12] Pending sets on transfer; interrupt only with its enable set.
// [RQ13] In address-detect mode delivered characters show ninth bit one.
// [RQ14] Software sets divisor, port enable, irq, nine-bit, then receive.
// [RQ15] Software reads status first, then the low eight data bits.
// [RQ16] Line oversampled 16x, start checked mid-bit, bits by majority.
// [RQ17] Pending stays while receiver enabled and FIFO holds a character.
// [RQ18] Each entry keeps its framing bit; status shows the head one.
// [RQ19] Stop sample zero marks a framing error, else error-free.
// [RQ20] Receive enable off then on resumes reception without overrun.
`ifndef AUR_DEFINES_SVH
`define AUR_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AUR_ADDR_W 3
`define AUR_OFS_DATA 3'h0
`define AUR_OFS_RECEIVE_STATUS_CONTROL 3'h1
`define AUR_OFS_DIV 3'h2
`define AUR_OFS_TRANSMIT_STATUS_CONTROL 3'h3
`define AUR_OFS_IRQ 3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AUR_RC_SERIAL_PORT_ENABLE 7
`define AUR_RC_RX9 6
`define AUR_RC_SREN 5
`define AUR_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define AUR_RC_ADDRESS_DETECT_ENABLE 3
`define AUR_TX_CSRC 7
`define AUR_TX_TX9 6
`define AUR_TX_TXEN 5
`define AUR_TX_SYNC 4
`define AUR_TX_HIGH_SPEED_BAUD_SELECT 2
`define AUR_TX_TX9D 0
`define AUR_IRQ_EN 0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define AUR_RST_RECEIVE_STATUS_CONTROL 8'h00
`define AUR_RST_TRANSMIT_STATUS_CONTROL 8'h02
`define AUR_RST_DIV 8'h00
`define AUR_OVS_LAST 4'hF
`define AUR_SMP_A 4'h7
`define AUR_SMP_B 4'h8
`define AUR_SMP_C 4'h9
`define AUR_LAST_BIT8 4'h7
`define AUR_LAST_BIT9 4'h8

`endif

// ---- inc/aur_pkg.sv ----
// Purpose: shared types of the asynchronous receiver
// Assumes: aur_defines.svh gives the widths
// Notes: none
`include "aur_defines.svh"

package aur_pkg;

    typedef struct packed {
        logic frameErr;
        logic [8:0] data;
    } aur_char_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`AUR_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } aur_bus_req_t;

    typedef enum logic [1:0] {
        AUR_IDLE = 2'b00,
        AUR_START = 2'b01,
        AUR_DATA = 2'b10,
        AUR_STOP = 2'b11
    } aur_rx_state_t;

endpackage

// ---- hw/aur_rx_fifo.sv ----
// Purpose: small receive FIFO of characters with framing bits
// Assumes: push and pop come from logic on ref_clk
// Notes: a push while full is dropped; the caller flags it
`timescale 1ns/1ns
`default_nettype none

module aur_rx_fifo
    import aur_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic pushValid,
    input wire aur_char_t pushData,
    output logic pushReady,
    input wire logic popReq,
    output logic headValid,
    output aur_char_t head
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    aur_char_t mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;

    wire doPush = pushValid && pushReady;
    wire doPop = popReq && headValid;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // [RQ1] two-entry limit
    assign pushReady = (count != CW'(DEPTH));
    assign headValid = (count != '0);
    // [RQ18] head entry fields
    assign head = mem[rdPtr];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            // Flush clears entries so stale framing status disappears
            always_ff @(posedge ref_clk) begin
                if (!rstn || flush) begin
                    mem[gi] <= '0;
                end else if (doPush && wrPtr == PW'(gi)) begin
                    mem[gi] <= pushData;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pointers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= bump(wrPtr);
            end
            if (doPop) begin
                rdPtr <= bump(rdPtr);
            end
            case ({doPush, doPop})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- hw/aur_rx_top.sv ----
// Purpose: asynchronous serial receiver with overrun and address detect
// Assumes: rxPin is asynchronous; register port on ref_clk
// Notes: baud divisor gives one 16x tick every divisor+1 clocks
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none

module aur_rx_top
    import aur_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire aur_bus_req_t busReq,
    output logic [7:0] regRdData,
    input wire logic rxPin,
    output logic rxIrq
);

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic portEn, nineEn, singleRx, contRx, addrDetect;
    logic clkSrc, txNine, txEn, syncMode, highSpeed, txNinth;
    logic [7:0] baudDiv;
    logic irqEn;
    logic overrun;

    wire wrRcsta = busReq.wr && busReq.addr == `AUR_OFS_RECEIVE_STATUS_CONTROL;
    wire wrTxsta = busReq.wr && busReq.addr == `AUR_OFS_TRANSMIT_STATUS_CONTROL;
    wire wrDiv = busReq.wr && busReq.addr == `AUR_OFS_DIV;
    wire wrIrq = busReq.wr && busReq.addr == `AUR_OFS_IRQ;
    wire rdData = busReq.rd && busReq.addr == `AUR_OFS_DATA;

    // Receiver runs only with port on, continuous receive, async mode
    wire rxActive = portEn && contRx && !syncMode;
    wire recvOn = portEn && contRx;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            {portEn, nineEn, singleRx, contRx, addrDetect} <= 5'h00;
        end else if (wrRcsta) begin
            portEn <= busReq.wdata[`AUR_RC_SERIAL_PORT_ENABLE];
            nineEn <= busReq.wdata[`AUR_RC_RX9];
            singleRx <= busReq.wdata[`AUR_RC_SREN];
            contRx <= busReq.wdata[`AUR_RC_CONTINUOUS_RECEIVE_ENABLE];
            addrDetect <= busReq.wdata[`AUR_RC_ADDRESS_DETECT_ENABLE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            {clkSrc, txNine, txEn, syncMode, highSpeed, txNinth} <= 6'h00;
        end else if (wrTxsta) begin
            clkSrc <= busReq.wdata[`AUR_TX_CSRC];
            txNine <= busReq.wdata[`AUR_TX_TX9];
            txEn <= busReq.wdata[`AUR_TX_TXEN];
            syncMode <= busReq.wdata[`AUR_TX_SYNC];
            highSpeed <= busReq.wdata[`AUR_TX_HIGH_SPEED_BAUD_SELECT];
            txNinth <= busReq.wdata[`AUR_TX_TX9D];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            baudDiv <= `AUR_RST_DIV;
            irqEn <= 1'b0;
        end else begin
            if (wrDiv) begin
                baudDiv <= busReq.wdata;
            end
            if (wrIrq) begin
                irqEn <= busReq.wdata[`AUR_IRQ_EN];
            end
        end
    end

    // ----------------------------------------------------------------
    // Line synchroniser and 16x tick
    // ----------------------------------------------------------------
    logic rxSync1, rxSync2, rxLast;
    logic [7:0] divCnt;
    logic sampleTick;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rxSync1 <= 1'b1;
            rxSync2 <= 1'b1;
            rxLast <= 1'b1;
        end else begin
            rxSync1 <= rxPin;
            rxSync2 <= rxSync1;
            rxLast <= rxSync2;
        end
    end

    // Divider restarts while idle so a start edge aligns the bit grid
    logic [1:0] rxState;
    wire divWrap = (divCnt == baudDiv);
    always_ff @(posedge ref_clk) begin
        if (!rstn || !rxActive || rxState == AUR_IDLE) begin
            divCnt <= 8'h00;
            sampleTick <= 1'b0;
        end else begin
            divCnt <= divWrap ? 8'h00 : divCnt + 8'h01;
            sampleTick <= divWrap;
        end
    end

    // ----------------------------------------------------------------
    // Bit recovery state machine
    // ----------------------------------------------------------------
    aur_rx_state_t state, next_state;
    logic [3:0] ovsCnt;
    logic [3:0] bitIdx;
    logic [8:0] shReg;
    logic frame9;
    logic smpA, smpB;

    assign rxState = state;
    wire startEdge = rxLast && !rxSync2;
    wire evalNow = sampleTick && ovsCnt == `AUR_SMP_C;
    wire bitEnd = sampleTick && ovsCnt == `AUR_OVS_LAST;
    wire [3:0] lastIdx = frame9 ? `AUR_LAST_BIT9 : `AUR_LAST_BIT8;
    // [RQ16] three-sample majority
    wire voteBit = (smpA & smpB) | (smpA & rxSync2) | (smpB & rxSync2);

    always_comb begin
        next_state = state;
        case (state)
            AUR_IDLE: begin
                if (startEdge) begin
                    next_state = AUR_START;
                end
            end
            AUR_START: begin
                // [RQ16] false start aborts silently
                if (evalNow && voteBit) begin
                    next_state = AUR_IDLE;
                end else if (bitEnd) begin
                    next_state = AUR_DATA;
                end
            end
            AUR_DATA: begin
                if (bitEnd && bitIdx == lastIdx) begin
                    next_state = AUR_STOP;
                end
            end
            AUR_STOP: begin
                if (evalNow) begin
                    next_state = AUR_IDLE;
                end
            end
            default: next_state = AUR_IDLE;
        endcase
        if (!rxActive) begin
            next_state = AUR_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= AUR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn || state == AUR_IDLE) begin
            ovsCnt <= 4'h0;
            smpA <= 1'b1;
            smpB <= 1'b1;
        end else if (sampleTick) begin
            ovsCnt <= ovsCnt + 4'h1;
            if (ovsCnt == `AUR_SMP_A) begin
                smpA <= rxSync2;
            end
            if (ovsCnt == `AUR_SMP_B) begin
                smpB <= rxSync2;
            end
        end
    end

    // [RQ4] width chosen at the start edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            frame9 <= 1'b0;
            bitIdx <= 4'h0;
            shReg <= 9'h000;
        end else if (state == AUR_IDLE) begin
            frame9 <= nineEn;
            bitIdx <= 4'h0;
            shReg <= 9'h000;
        end else if (state == AUR_DATA) begin
            if (evalNow) begin
                shReg[bitIdx] <= voteBit;
            end
            if (bitEnd) begin
                bitIdx <= bitIdx + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Character transfer, filtering and overrun
    // ----------------------------------------------------------------
    aur_char_t newChar, head;
    logic pushReady, headValid;

    // A receiver switched off in mid stop bit must not deliver its character
    wire charDone = (state == AUR_STOP) && evalNow && rxActive;
    // [RQ19] stop sample decides framing
    assign newChar.frameErr = !voteBit;
    assign newChar.data = shReg;
    // [RQ7] [RQ11] filter on ninth bit only with address detect
    wire wantStore = !addrDetect || shReg[8];
    // [RQ2] nothing enters while overrun stands
    wire pushValid = charDone && wantStore && !overrun;
    // [RQ1] third complete character finds FIFO full
    wire overrunHit = pushValid && !pushReady;

    // [RQ3] [RQ20] clearing receive enable drops overrun; set wins
    wire next_overrun = overrunHit || (overrun && contRx && portEn);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            overrun <= 1'b0;
        end else begin
            overrun <= next_overrun;
        end
    end

    // Port disable resets the unit, clearing held framing status
    aur_rx_fifo #(
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .flush(!portEn),
        .pushValid(pushValid),
        .pushData(newChar),
        .pushReady(pushReady),
        .popReq(rdData),
        .headValid(headValid),
        .head(head)
    );

    // ----------------------------------------------------------------
    // Read path, pending flag and interrupt
    // ----------------------------------------------------------------
    logic pending;
    logic [7:0] readMux;
    // [RQ5] [RQ13] [RQ18] status built from the head entry
    wire [7:0] rcstaRead = {portEn, nineEn, singleRx, contRx, addrDetect,
                            head.frameErr, overrun, head.data[8]};
    wire [7:0] txstaRead = {clkSrc, txNine, txEn, syncMode, 1'b0,
                            highSpeed, 1'b1, txNinth};
    wire [7:0] irqRead = {6'h00, pending, irqEn};
    // [RQ17] pending follows unread data while enabled
    wire next_pending = recvOn && headValid;

    always_comb begin
        if (busReq.addr == `AUR_OFS_DATA) begin
            readMux = head.data[7:0];
        end else if (busReq.addr == `AUR_OFS_RECEIVE_STATUS_CONTROL) begin
            readMux = rcstaRead;
        end else if (busReq.addr == `AUR_OFS_DIV) begin
            readMux = baudDiv;
        end else if (busReq.addr == `AUR_OFS_TRANSMIT_STATUS_CONTROL) begin
            readMux = txstaRead;
        end else if (busReq.addr == `AUR_OFS_IRQ) begin
            readMux = irqRead;
        end else begin
            readMux = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
            pending <= 1'b0;
            rxIrq <= 1'b0;
        end else begin
            regRdData <= busReq.rd ? readMux : 8'h00;
            // [RQ12] pending regardless of enable, request gated
            pending <= next_pending;
            rxIrq <= next_pending && irqEn;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence fullHit_s;
        charDone && wantStore && !overrun && !pushReady;
    endsequence

    sequence pushed_s;
        pushValid && pushReady;
    endsequence

    ovr_set_a: assert property ( // [RQ1]
        @(posedge ref_clk) disable iff (!rstn)
        fullHit_s |=> overrun && (!pushReady || $past(rdData)))
        else $error("overrun not raised on full FIFO");

    ovr_block_a: assert property ( // [RQ2]
        @(posedge ref_clk) disable iff (!rstn)
        overrun && portEn && !rdData
        |=> $stable(head) && !($rose(headValid)))
        else $error("FIFO changed during overrun");

    ovr_clear_a: assert property ( // [RQ3]
        @(posedge ref_clk) disable iff (!rstn)
        overrun && !contRx |=> !overrun)
        else $error("overrun survived receive disable");

    ninth_head_a: assert property ( // [RQ5]
        @(posedge ref_clk) disable iff (!rstn)
        busReq.rd && busReq.addr == `AUR_OFS_RECEIVE_STATUS_CONTROL
        |=> regRdData[0] == $past(head.data[8]))
        else $error("ninth bit status not from head");

    addr_drop_a: assert property ( // [RQ7]
        @(posedge ref_clk) disable iff (!rstn)
        charDone && addrDetect && !shReg[8] |-> !pushValid ##1 !overrun
        || $past(overrun))
        else $error("non-address character stored");

    store_all_a: assert property ( // [RQ11]
        @(posedge ref_clk) disable iff (!rstn)
        charDone && !addrDetect && !overrun && pushReady && rxActive
        |=> ##1 (pending || !$past(recvOn)))
        else $error("character not stored or pending");

    pend_set_a: assert property ( // [RQ12]
        @(posedge ref_clk) disable iff (!rstn)
        pushed_s ##0 recvOn ##1 recvOn
        |=> pending && (rxIrq == $past(irqEn)))
        else $error("pending or request wrong after transfer");

    addr_ninth_a: assert property ( // [RQ13]
        @(posedge ref_clk) disable iff (!rstn)
        pushed_s ##0 addrDetect |=> $past(newChar.data[8]))
        else $error("address mode stored ninth bit zero");

    frame_err_a: assert property ( // [RQ19]
        @(posedge ref_clk) disable iff (!rstn)
        pushed_s ##0 !headValid |=> head.frameErr == $past(!voteBit))
        else $error("framing bit not from stop sample");

    start_abort_a: assert property ( // [RQ16]
        @(posedge ref_clk) disable iff (!rstn)
        state == AUR_START && evalNow && voteBit |=> state == AUR_IDLE)
        else $error("false start not aborted");

    nine_len_a: assert property ( // [RQ4]
        @(posedge ref_clk) disable iff (!rstn)
        state == AUR_DATA ##1 state == AUR_STOP
        |-> $past(bitIdx) == (frame9 ? 4'h8 : 4'h7))
        else $error("wrong number of data bits");

endmodule

`default_nettype wire

// ---- testbench/aur_tx_model.sv ----
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: divisor 0, so one bit lasts 16 clocks of ref_clk
// Notes: the line rests high between frames, as a mark level
`timescale 1ns/1ns
`default_nettype none

module aur_tx_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic ref_clk,
    output logic txLine
);
    initial txLine = 1'b1;

    // ------------------------------------------------------------
    // Frame drivers
    // ------------------------------------------------------------
    // One start, 8 or 9 data bits LSB first, one stop, then idle gap
    task automatic sendChar(input logic [8:0] value, input logic nine,
                            input logic stopLvl, input int gapBits);
        int i;
        @(posedge ref_clk);
        txLine <= 1'b0;
        repeat (BIT_CLKS) @(posedge ref_clk);
        for (i = 0; i < 9; i++) begin
            if (i < 8 || nine) begin
                txLine <= value[i];
                repeat (BIT_CLKS) @(posedge ref_clk);
            end
        end
        txLine <= stopLvl;
        repeat (BIT_CLKS) @(posedge ref_clk);
        txLine <= 1'b1;
        repeat (gapBits * BIT_CLKS) @(posedge ref_clk);
    endtask

    // Short low glitch that must not pass the mid-bit start check
    task automatic glitch(input int lowClks);
        @(posedge ref_clk);
        txLine <= 1'b0;
        repeat (lowClks) @(posedge ref_clk);
        txLine <= 1'b1;
        repeat (12 * BIT_CLKS) @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// ---- testbench/aur_rx_top_tb.sv ----
// Purpose: self-checking bench of the asynchronous receiver
// Assumes: register port with read data one cycle after the strobe
// Notes: divisor stays 0 during traffic, 16 clocks per bit
`timescale 1ns/1ns
`default_nettype none

module aur_rx_top_tb
    import aur_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn;
    aur_bus_req_t busReq;
    logic [7:0] regRdData;
    logic rxPin;
    logic rxIrq;
    int errTotal = 0;
    int cmpCount = 0;

    always #5 ref_clk = ~ref_clk;

    aur_rx_top #(.FIFO_DEPTH(2)) u_dut (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .busReq(busReq),
        .regRdData(regRdData),
        .rxPin(rxPin),
        .rxIrq(rxIrq)
    );

    aur_tx_model #(.BIT_CLKS(16)) u_tx (
        .ref_clk(ref_clk),
        .txLine(rxPin)
    );

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        busReq <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic expectReg(input string what, input logic [2:0] a,
                             input logic [7:0] exp);
        @(posedge ref_clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        busReq <= '0;
        #1;
        check(what, regRdData, exp);
    endtask

    task automatic closeOut();
        if (errTotal == 0 && cmpCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is near 3300 cycles; this leaves ample margin
    initial begin
        repeat (30000) @(posedge ref_clk);
        errTotal++;
        closeOut();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        busReq = '0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        expectReg("status reset", 3'h1, 8'h00);
        expectReg("divisor reset", 3'h2, 8'h00);
        expectReg("txstat reset", 3'h3, 8'h02);
        expectReg("irq reset", 3'h4, 8'h00);
        wrReg(3'h5, 8'hFF);
        expectReg("unmapped", 3'h5, 8'h00);
        wrReg(3'h2, 8'h5A);
        expectReg("divisor rw", 3'h2, 8'h5A);
        wrReg(3'h2, 8'h00);
        // Setup order: divisor, port, irq, then width and receive in one write
        wrReg(3'h1, 8'h80);
        wrReg(3'h4, 8'h01);
        wrReg(3'h1, 8'h90);
        u_tx.sendChar(9'h0A5, 1'b0, 1'b1, 1);
        check("irq line", {7'h00, rxIrq}, 8'h01);
        expectReg("pending set", 3'h4, 8'h03);
        expectReg("status clean", 3'h1, 8'h90);
        expectReg("data 8bit", 3'h0, 8'hA5);
        expectReg("pending gone", 3'h4, 8'h01);
        check("irq drop", {7'h00, rxIrq}, 8'h00);
        // Framing bit travels with its own entry
        u_tx.sendChar(9'h03C, 1'b0, 1'b0, 1);
        u_tx.sendChar(9'h0C3, 1'b0, 1'b1, 3);
        expectReg("framing_error_flag head", 3'h1, 8'h94);
        expectReg("data framing_error_flag", 3'h0, 8'h3C);
        expectReg("framing_error_flag next", 3'h1, 8'h90);
        expectReg("data ok", 3'h0, 8'hC3);
        // Third whole character with two unread gives overrun
        u_tx.sendChar(9'h011, 1'b0, 1'b1, 1);
        u_tx.sendChar(9'h022, 1'b0, 1'b1, 1);
        expectReg("no overrun", 3'h1, 8'h90);
        u_tx.sendChar(9'h033, 1'b0, 1'b1, 1);
        expectReg("overrun", 3'h1, 8'h92);
        expectReg("held first", 3'h0, 8'h11);
        u_tx.sendChar(9'h044, 1'b0, 1'b1, 1);
        expectReg("held second", 3'h0, 8'h22);
        expectReg("nothing new", 3'h4, 8'h01);
        expectReg("overrun held", 3'h1, 8'h92);
        wrReg(3'h1, 8'h80);
        expectReg("overrun clear", 3'h1, 8'h80);
        wrReg(3'h1, 8'h90);
        u_tx.sendChar(9'h055, 1'b0, 1'b1, 1);
        expectReg("resume", 3'h0, 8'h55);
        // Nine-bit characters, ninth bit read before data
        wrReg(3'h1, 8'hD0);
        u_tx.sendChar(9'h1AB, 1'b1, 1'b1, 1);
        u_tx.sendChar(9'h0CD, 1'b1, 1'b1, 2);
        expectReg("ninth one", 3'h1, 8'hD1);
        expectReg("data9 a", 3'h0, 8'hAB);
        expectReg("ninth zero", 3'h1, 8'hD0);
        expectReg("data9 b", 3'h0, 8'hCD);
        // Address filter drops data characters silently
        wrReg(3'h1, 8'hD8);
        u_tx.sendChar(9'h012, 1'b1, 1'b1, 1);
        expectReg("dropped", 3'h4, 8'h01);
        u_tx.sendChar(9'h1F0, 1'b1, 1'b1, 1);
        expectReg("addr status", 3'h1, 8'hD9);
        expectReg("addr data", 3'h0, 8'hF0);
        wrReg(3'h1, 8'hD0);
        u_tx.sendChar(9'h034, 1'b1, 1'b1, 1);
        expectReg("msg status", 3'h1, 8'hD0);
        expectReg("msg data", 3'h0, 8'h34);
        wrReg(3'h1, 8'hD8);
        u_tx.sendChar(9'h077, 1'b1, 1'b1, 1);
        expectReg("refilter", 3'h4, 8'h01);
        // Short glitch aborts without error or character
        u_tx.glitch(5);
        expectReg("glitch", 3'h4, 8'h01);
        // Empty FIFO shows the stale entry at the read pointer (1F0), ninth bit one
        expectReg("glitch stat", 3'h1, 8'hD9);
        // Masked request: flag still rises, line stays low
        wrReg(3'h4, 8'h00);
        wrReg(3'h1, 8'h90);
        u_tx.sendChar(9'h069, 1'b0, 1'b1, 1);
        check("irq masked", {7'h00, rxIrq}, 8'h00);
        expectReg("pending masked", 3'h4, 8'h02);
        expectReg("masked data", 3'h0, 8'h69);
        // Sync mode keeps the asynchronous receiver idle
        wrReg(3'h3, 8'hFF);
        expectReg("txstat rw", 3'h3, 8'hF7);
        u_tx.sendChar(9'h05A, 1'b0, 1'b1, 1);
        expectReg("sync idle", 3'h4, 8'h00);
        closeOut();
    end
endmodule

`default_nettype wire
